/* File: rara_pkg.sv */
// constants shared by the rail A configuration register block
// assumes one 25 MHz logic clock and a two-wire serial management port
`default_nettype none

package rara_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int          REG_WIDTH          = 8;
  localparam int          REG_COUNT          = 3;
  localparam logic [7:0]  SOFTSTART_SCALE_OFS = 8'h24;
  localparam logic [7:0]  LOADLINE_GAIN_OFS   = 8'h25;
  localparam logic [7:0]  ZERO_CURRENT_OFS    = 8'h26;
  localparam logic [7:0]  SOFTSTART_SCALE_RST = 8'h00;
  localparam logic [7:0]  LOADLINE_GAIN_RST   = 8'hd0;
  localparam logic [7:0]  ZERO_CURRENT_RST    = 8'hc0;
  localparam logic [7:0]  UNMAPPED_READ       = 8'h00;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int SS_ENABLE_BIT  = 7;
  localparam int SS_MULT_MSB    = 6;
  localparam int SS_MULT_LSB    = 4;
  localparam int SCALE_MSB      = 2;
  localparam int SCALE_LSB      = 0;
  localparam int ZLL_ENABLE_BIT = 3;
  localparam int GAIN_MSB       = 2;
  localparam int GAIN_LSB       = 0;
  localparam int ZC_SIGN_BIT    = 5;
  localparam int ZC_MAG_MSB     = 4;
  localparam int ZC_MAG_LSB     = 0;
  localparam logic [2:0] SCALE_CUSTOM_CODE = 3'h0;
  localparam logic [4:0] ZC_MAG_ZERO       = 5'h00;

  // ---------------------------------------------------------------
  // serial port
  // ---------------------------------------------------------------
  localparam int         DEV_ADDR_WIDTH   = 7;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h20; // arbitrary value
  localparam logic [2:0] LAST_BIT         = 3'h7;

  typedef enum logic [3:0] {
    SER_IDLE    = 4'b0000,
    SER_ADDR    = 4'b0001,
    SER_ACK_ADR = 4'b0010,
    SER_PTR     = 4'b0011,
    SER_ACK_PTR = 4'b0100,
    SER_WR      = 4'b0101,
    SER_ACK_WR  = 4'b0110,
    SER_RD      = 4'b0111,
    SER_ACK_RD  = 4'b1000
  } rara_ser_state_type;

endpackage : rara_pkg

`default_nettype wire

/* File: rara_regbus_if.sv */
// byte-wide register access between the serial engine and the bank
// assumes both ends run on the same clock
`default_nettype none

interface rara_regbus_if;
  logic       wr_en;   // one-cycle write strobe
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data; // combinational answer to rd_addr

  modport master (output wr_en, output wr_addr, output wr_data, output rd_addr,
                  input rd_data);
  modport slave  (input wr_en, input wr_addr, input wr_data, input rd_addr,
                  output rd_data);
endinterface : rara_regbus_if

`default_nettype wire

/* File: rara_reg_bank.sv */
// the three rail A configuration registers and their decoded fields
// assumes writes arrive as single-cycle strobes from the serial engine
`default_nettype none

module rara_reg_bank
  import rara_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // register access
  rara_regbus_if.slave     bus,
  // decoded fields
  output var  logic        ss_ocp_enable,
  output var  logic [2:0]  ss_ocp_mult,
  output var  logic [2:0]  current_scale,
  output var  logic        scale_custom,
  output var  logic        zero_loadline_enable,
  output var  logic [2:0]  current_sense_gain,
  output var  logic        zero_current_negative,
  output var  logic [4:0]  zero_current_magnitude
);

  localparam logic [7:0] RST_VALUE [REG_COUNT] =
    '{SOFTSTART_SCALE_RST, LOADLINE_GAIN_RST, ZERO_CURRENT_RST};

  logic [7:0] regs      [REG_COUNT];
  logic [7:0] next_regs [REG_COUNT];
  logic       next_scale_custom;
  logic       next_zc_negative;

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic in_map(input logic [7:0] addr);
    in_map = (addr >= SOFTSTART_SCALE_OFS) && (addr <= ZERO_CURRENT_OFS);
  endfunction : in_map

  function automatic logic [1:0] reg_index(input logic [7:0] addr);
    logic [7:0] diff;
    diff      = addr - SOFTSTART_SCALE_OFS;
    reg_index = diff[1:0];
  endfunction : reg_index

  // reads return whole bytes, reserved bits included
  assign bus.rd_data = in_map(bus.rd_addr) ? regs[reg_index(bus.rd_addr)]
                                           : UNMAPPED_READ;

  // writes store every bit; reserved patterns are the writer's duty
  always_comb
  begin
    for (int i = 0; i < REG_COUNT; i++)
    begin
      next_regs[i] = regs[i];
    end
    if (bus.wr_en && in_map(bus.wr_addr))
    begin
      next_regs[reg_index(bus.wr_addr)] = bus.wr_data;
    end
    next_scale_custom = (next_regs[0][SCALE_MSB:SCALE_LSB] == SCALE_CUSTOM_CODE);
    // a signed zero is still zero, so minus only with a nonzero magnitude
    next_zc_negative  = next_regs[2][ZC_SIGN_BIT] &&
                        (next_regs[2][ZC_MAG_MSB:ZC_MAG_LSB] != ZC_MAG_ZERO);
  end

  // storage with documented defaults, reserved patterns included
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs[i] <= RST_VALUE[i];
      end
      // flags follow the register defaults so both agree from the first edge
      scale_custom          <= (SOFTSTART_SCALE_RST[SCALE_MSB:SCALE_LSB] == SCALE_CUSTOM_CODE);
      zero_current_negative <= ZERO_CURRENT_RST[ZC_SIGN_BIT] &&
                               (ZERO_CURRENT_RST[ZC_MAG_MSB:ZC_MAG_LSB] != ZC_MAG_ZERO);
    end
    else
    begin
      for (int i = 0; i < REG_COUNT; i++)
      begin
        regs[i] <= next_regs[i];
      end
      scale_custom          <= next_scale_custom;
      zero_current_negative <= next_zc_negative;
    end
  end

  // ---------------------------------------------------------------
  // field views, each a slice of a flip-flop
  // ---------------------------------------------------------------
  assign ss_ocp_enable          = regs[0][SS_ENABLE_BIT];
  assign ss_ocp_mult            = regs[0][SS_MULT_MSB:SS_MULT_LSB];
  assign current_scale          = regs[0][SCALE_MSB:SCALE_LSB];
  assign zero_loadline_enable   = regs[1][ZLL_ENABLE_BIT];
  assign current_sense_gain     = regs[1][GAIN_MSB:GAIN_LSB];
  assign zero_current_magnitude = regs[2][ZC_MAG_MSB:ZC_MAG_LSB];

endmodule : rara_reg_bank

`default_nettype wire

/* File: rara_cfg_regs.sv */
// rail A configuration registers behind a two-wire serial slave port
// assumes SCL and SDA come straight from pins and a 25 MHz logic clock
// well above the serial bit rate; SDA is open drain, pulled up outside
`default_nettype none

module rara_cfg_regs
  import rara_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = rara_pkg::DEV_ADDR_DEFAULT
)
(
  // clock and reset
  input  wire logic        CLOCK,
  input  wire logic        RST_B,
  // serial pins
  input  wire logic        SCL,
  input  wire logic        SDA_IN,
  output var  logic        SDA_OUT,
  output var  logic        SDA_OE_B,
  // soft-start and scale settings
  output var  logic        SS_OCP_ENABLE,
  output var  logic [2:0]  SS_OCP_MULT,
  output var  logic [2:0]  CURRENT_SCALE,
  output var  logic        SCALE_CUSTOM,
  // load-line and gain settings
  output var  logic        ZERO_LOADLINE_ENABLE,
  output var  logic [2:0]  CURRENT_SENSE_GAIN,
  // zero-current threshold
  output var  logic        ZERO_CURRENT_NEGATIVE,
  output var  logic [4:0]  ZERO_CURRENT_MAGNITUDE
);

  rara_regbus_if bus ();

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic scl_meta;
  logic scl_sync;
  logic scl_prev;
  logic sda_meta;
  logic sda_sync;
  logic sda_prev;

  // the first stage feeds only the second; edges use sync and prev
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_prev <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      scl_meta <= SCL;
      scl_sync <= scl_meta;
      scl_prev <= scl_sync;
      sda_meta <= SDA_IN;
      sda_sync <= sda_meta;
      sda_prev <= sda_sync;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  // sda moving while scl is high marks frame start and stop
  assign scl_rise   = scl_sync && !scl_prev;
  assign scl_fall   = !scl_sync && scl_prev;
  assign start_seen = scl_sync && scl_prev && sda_prev && !sda_sync;
  assign stop_seen  = scl_sync && scl_prev && !sda_prev && sda_sync;

  // ---------------------------------------------------------------
  // serial engine
  // ---------------------------------------------------------------
  rara_ser_state_type state;
  rara_ser_state_type next_state;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic [7:0] shift;
  logic [7:0] next_shift;
  logic [7:0] pointer;
  logic [7:0] next_pointer;
  logic       byte_done;
  logic       next_byte_done;
  logic       is_read;
  logic       next_is_read;
  logic       nack;
  logic       next_nack;
  logic       next_oe_b;
  logic       wr_en;
  logic       next_wr_en;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;

  function automatic logic receiving(input rara_ser_state_type s);
    receiving = (s == SER_ADDR) || (s == SER_PTR) || (s == SER_WR);
  endfunction : receiving

  always_comb
  begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_shift     = shift;
    next_pointer   = pointer;
    next_byte_done = byte_done;
    next_is_read   = is_read;
    next_nack      = nack;
    next_oe_b      = SDA_OE_B;
    next_wr_en     = 1'b0;
    next_wr_addr   = wr_addr;
    next_wr_data   = wr_data;
    if (start_seen)
    begin
      // a repeated start keeps the pointer so reads follow a pointer write
      next_state     = SER_ADDR;
      next_bit_cnt   = 3'h0;
      next_byte_done = 1'b0;
      next_oe_b      = 1'b1;
    end
    else if (stop_seen)
    begin
      next_state = SER_IDLE;
      next_oe_b  = 1'b1;
    end
    else if (scl_rise)
    begin
      if (receiving(state))
      begin
        next_shift     = {shift[6:0], sda_sync};
        next_bit_cnt   = bit_cnt + 3'h1;
        next_byte_done = (bit_cnt == LAST_BIT);
      end
      else if (state == SER_ACK_RD)
      begin
        next_nack = sda_sync; // high means the master wants no more
      end
    end
    else if (scl_fall)
    begin
      unique case (state)
        SER_IDLE:
        begin
          next_oe_b = 1'b1;
        end
        SER_ADDR:
        begin
          if (byte_done)
          begin
            next_byte_done = 1'b0;
            if (shift[7:1] == DEV_ADDR)
            begin
              next_is_read = shift[0];
              next_oe_b    = 1'b0;
              next_state   = SER_ACK_ADR;
            end
            else
            begin
              next_state = SER_IDLE;
            end
          end
        end
        SER_PTR:
        begin
          if (byte_done)
          begin
            next_byte_done = 1'b0;
            next_pointer   = shift;
            next_oe_b      = 1'b0;
            next_state     = SER_ACK_PTR;
          end
        end
        SER_WR:
        begin
          if (byte_done)
          begin
            // every byte at a mapped offset is stored, reserved bits too; keeping them is the writer's job
            next_byte_done = 1'b0;
            next_wr_en     = 1'b1;
            next_wr_addr   = pointer;
            next_wr_data   = shift;
            next_pointer   = pointer + 8'h01;
            next_oe_b      = 1'b0;
            next_state     = SER_ACK_WR;
          end
        end
        SER_ACK_ADR:
        begin
          if (is_read)
          begin
            next_shift   = bus.rd_data;
            next_oe_b    = bus.rd_data[7];
            next_bit_cnt = 3'h0;
            next_state   = SER_RD;
          end
          else
          begin
            next_oe_b  = 1'b1;
            next_state = SER_PTR;
          end
        end
        SER_ACK_PTR, SER_ACK_WR:
        begin
          next_oe_b  = 1'b1;
          next_state = SER_WR;
        end
        SER_RD:
        begin
          if (bit_cnt == LAST_BIT)
          begin
            next_oe_b    = 1'b1;
            next_pointer = pointer + 8'h01;
            next_state   = SER_ACK_RD;
          end
          else
          begin
            next_shift   = {shift[6:0], 1'b0};
            next_oe_b    = shift[6];
            next_bit_cnt = bit_cnt + 3'h1;
          end
        end
        SER_ACK_RD:
        begin
          if (nack)
          begin
            next_state = SER_IDLE;
          end
          else
          begin
            next_shift   = bus.rd_data;
            next_oe_b    = bus.rd_data[7];
            next_bit_cnt = 3'h0;
            next_state   = SER_RD;
          end
        end
        default:
        begin
          next_state = SER_IDLE;
          next_oe_b  = 1'b1;
        end
      endcase
    end
  end

  // engine registers; the pin only ever pulls low, never drives high
  always_ff @(posedge CLOCK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state     <= SER_IDLE;
      bit_cnt   <= 3'h0;
      shift     <= 8'h00;
      pointer   <= 8'h00;
      byte_done <= 1'b0;
      is_read   <= 1'b0;
      nack      <= 1'b0;
      SDA_OE_B  <= 1'b1;
      SDA_OUT   <= 1'b0;
      wr_en     <= 1'b0;
      wr_addr   <= 8'h00;
      wr_data   <= 8'h00;
    end
    else
    begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      shift     <= next_shift;
      pointer   <= next_pointer;
      byte_done <= next_byte_done;
      is_read   <= next_is_read;
      nack      <= next_nack;
      SDA_OE_B  <= next_oe_b;
      SDA_OUT   <= 1'b0;
      wr_en     <= next_wr_en;
      wr_addr   <= next_wr_addr;
      wr_data   <= next_wr_data;
    end
  end

  assign bus.wr_en   = wr_en;
  assign bus.wr_addr = wr_addr;
  assign bus.wr_data = wr_data;
  assign bus.rd_addr = pointer;

  // ---------------------------------------------------------------
  // register bank
  // ---------------------------------------------------------------
  rara_reg_bank u_bank (
    .clock                  (CLOCK),
    .rst_b                  (RST_B),
    .bus                    (bus.slave),
    .ss_ocp_enable          (SS_OCP_ENABLE),
    .ss_ocp_mult            (SS_OCP_MULT),
    .current_scale          (CURRENT_SCALE),
    .scale_custom           (SCALE_CUSTOM),
    .zero_loadline_enable   (ZERO_LOADLINE_ENABLE),
    .current_sense_gain     (CURRENT_SENSE_GAIN),
    .zero_current_negative  (ZERO_CURRENT_NEGATIVE),
    .zero_current_magnitude (ZERO_CURRENT_MAGNITUDE)
  );

endmodule : rara_cfg_regs

`default_nettype wire

/* File: rara_cfg_regs_asserts.sv */
// pin-level checks for the rail A configuration register block
// assumes one clock domain and an active-low asynchronous reset
`default_nettype none

module rara_cfg_regs_asserts
  import rara_pkg::*;
(
  // clock and reset
  input wire logic       CLOCK,
  input wire logic       RST_B,
  // serial pins
  input wire logic       SCL,
  input wire logic       SDA_IN,
  input wire logic       SDA_OUT,
  input wire logic       SDA_OE_B,
  // settings
  input wire logic       SS_OCP_ENABLE,
  input wire logic [2:0] SS_OCP_MULT,
  input wire logic [2:0] CURRENT_SCALE,
  input wire logic       SCALE_CUSTOM,
  input wire logic       ZERO_LOADLINE_ENABLE,
  input wire logic [2:0] CURRENT_SENSE_GAIN,
  input wire logic       ZERO_CURRENT_NEGATIVE,
  input wire logic [4:0] ZERO_CURRENT_MAGNITUDE
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_B);

  // all settings in one word so a stray update anywhere is caught
  wire logic [17:0] fields;
  assign fields = {SS_OCP_ENABLE, SS_OCP_MULT, CURRENT_SCALE, SCALE_CUSTOM,
                   ZERO_LOADLINE_ENABLE, CURRENT_SENSE_GAIN, ZERO_CURRENT_NEGATIVE,
                   ZERO_CURRENT_MAGNITUDE};

  sequence s_scl_high; SCL [*2]; endsequence
  sequence s_released; SDA_OE_B [*3]; endsequence
  sequence s_ack_to_rise; ##[1:14] $rose(SCL); endsequence

  property p_custom; SCALE_CUSTOM == (CURRENT_SCALE == 3'h0); endproperty
  property p_neg; ZERO_CURRENT_NEGATIVE |-> ZERO_CURRENT_MAGNITUDE != 5'h00; endproperty
  property p_reset_val; $rose(RST_B) |-> fields == 18'h00400; endproperty
  property p_hold_high; s_scl_high |-> $stable(fields); endproperty
  property p_after_fall; $changed(fields) |-> !SCL && $past(SCL, 8); endproperty
  property p_oe_low_scl; $changed(SDA_OE_B) |-> !SCL; endproperty
  property p_oe_span; $fell(SDA_OE_B) |-> !SDA_OE_B throughout s_ack_to_rise; endproperty
  property p_oe_idle; $rose(RST_B) |-> s_released; endproperty
  property p_out_low; SDA_OUT == 1'b0; endproperty

  a_custom: assert property (p_custom) else $error("custom flag off");
  a_neg: assert property (p_neg) else $error("zero shown negative");
  a_reset_val: assert property (p_reset_val) else $error("bad defaults");
  a_hold_high: assert property (p_hold_high) else $error("setting moved, scl high");
  a_after_fall: assert property (p_after_fall) else $error("setting moved off-slot");
  a_oe_low_scl: assert property (p_oe_low_scl) else $error("sda changed, scl high");
  a_oe_span: assert property (p_oe_span) else $error("sda released early");
  a_oe_idle: assert property (p_oe_idle) else $error("sda driven after reset");
  a_out_low: assert property (p_out_low) else $error("sda data not low");
endmodule : rara_cfg_regs_asserts

bind rara_cfg_regs rara_cfg_regs_asserts u_asserts (.CLOCK(CLOCK), .RST_B(RST_B), .SCL(SCL),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_B(SDA_OE_B), .SS_OCP_ENABLE(SS_OCP_ENABLE),
  .SS_OCP_MULT(SS_OCP_MULT), .CURRENT_SCALE(CURRENT_SCALE), .SCALE_CUSTOM(SCALE_CUSTOM),
  .ZERO_LOADLINE_ENABLE(ZERO_LOADLINE_ENABLE), .CURRENT_SENSE_GAIN(CURRENT_SENSE_GAIN),
  .ZERO_CURRENT_NEGATIVE(ZERO_CURRENT_NEGATIVE),
  .ZERO_CURRENT_MAGNITUDE(ZERO_CURRENT_MAGNITUDE));

`default_nettype wire

/* File: tb_rara_cfg_regs.sv */
// self-checking bench for the rail A configuration registers
// assumes the device is alone on the serial bus, SDA pulled up
`default_nettype none

module tb_rara_cfg_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import rara_pkg::*;

`define CHK(nm, ex, gt) begin total_checks++; if ((gt) !== (ex)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, ex, gt); end end

  // ---------------------------------------------------------------
  // signals and device
  // ---------------------------------------------------------------
  logic        clock, rst_b, scl, sda_m, sda, sda_out, sda_oe_b;
  logic        ss_en, custom, zll, neg;
  logic [2:0]  mult, scale, gain, cc;
  logic [4:0]  mag;
  logic [7:0]  shadow [3];
  logic [7:0]  zc [8] = '{8'hc0, 8'he0, 8'hc1, 8'he1, 8'hdf, 8'hff, 8'hd5, 8'hea};
  logic [7:0]  ofs;
  logic [31:0] seed = 32'h44ef4549;
  int          n_fail = 0;
  int          total_checks = 0;

  // open drain: a released line shows the master or the pull-up
  assign sda = sda_oe_b ? sda_m : sda_out;

  rara_cfg_regs DUT (.CLOCK(clock), .RST_B(rst_b), .SCL(scl), .SDA_IN(sda),
    .SDA_OUT(sda_out), .SDA_OE_B(sda_oe_b), .SS_OCP_ENABLE(ss_en), .SS_OCP_MULT(mult),
    .CURRENT_SCALE(scale), .SCALE_CUSTOM(custom), .ZERO_LOADLINE_ENABLE(zll),
    .CURRENT_SENSE_GAIN(gain), .ZERO_CURRENT_NEGATIVE(neg), .ZERO_CURRENT_MAGNITUDE(mag));

  // 25 MHz logic clock
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // software keeps reserved bits at their defaults
  function automatic logic [7:0] legal(input logic [7:0] o, input logic [7:0] s);
    case (o)
      8'h24: return {s[7:4], 1'b0, s[2:0]};
      8'h25: return {4'hd, s[3:0]};
      8'h26: return {2'b11, s[5:0]};
      default: return s;
    endcase
  endfunction : legal

  function automatic logic [7:0] exp_reg(input logic [7:0] o);
    return (o >= 8'h24 && o <= 8'h26) ? shadow[o - 8'h24] : 8'h00;
  endfunction : exp_reg

  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick

  // one bit; six clocks of margin keep well clear of the synchronisers
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    tick(6);
    scl = 1'b1;
    tick(6);
    r = sda;
    scl = 1'b0;
    tick(6);
  endtask : bitx

  task automatic start;
    sda_m = 1'b1;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b0;
    tick(6);
    scl = 1'b0;
    tick(6);
  endtask : start

  task automatic stop;
    sda_m = 1'b0;
    tick(6);
    scl = 1'b1;
    tick(6);
    sda_m = 1'b1;
    tick(6);
  endtask : stop

  task automatic byte_x(input logic [7:0] d, input logic last, output logic [7:0] q,
                        output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(last, a);
  endtask : byte_x

  task automatic wr(input logic [6:0] dev, input logic [7:0] o0, input int n,
                    input logic [23:0] d);
    logic [7:0] q;
    logic [7:0] o;
    logic       a;
    start();
    byte_x({dev, 1'b0}, 1'b1, q, a);
    `CHK("address ack", dev != DEV_ADDR_DEFAULT, a)
    if (!a)
    begin
      byte_x(o0, 1'b1, q, a);
      for (int i = 0; i < n; i++)
      begin
        byte_x(d[23 - 8 * i -: 8], 1'b1, q, a);
        `CHK("data ack", 1'b0, a)
        o = o0 + 8'(i);
        if (o >= 8'h24 && o <= 8'h26) shadow[o - 8'h24] = d[23 - 8 * i -: 8];
      end
    end
    stop();
  endtask : wr

  task automatic check_reg(input logic [7:0] o);
    logic [7:0] q;
    logic       a;
    start();
    byte_x({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
    byte_x(o, 1'b1, q, a);
    start();
    byte_x({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, q, a);
    byte_x(8'hff, 1'b1, q, a);
    stop();
    `CHK("readback", exp_reg(o), q)
  endtask : check_reg

  // one read frame across the map with master acks, then a write cut by a stop
  task automatic check_burst;
    logic [7:0] q;
    logic       a;
    start();
    byte_x({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
    byte_x(8'h24, 1'b1, q, a);
    start();
    byte_x({DEV_ADDR_DEFAULT, 1'b1}, 1'b1, q, a);
    for (int i = 0; i < 3; i++)
    begin
      byte_x(8'hff, i == 2, q, a);
      `CHK("burst read", shadow[i], q)
    end
    stop();
    start();
    byte_x({DEV_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
    byte_x(8'h24, 1'b1, q, a);
    for (int i = 0; i < 4; i++) bitx(~shadow[0][7 - i], a);
    stop();
    check_reg(8'h24);
  endtask : check_burst

  task automatic check_fields;
    logic [7:0] a, b, c;
    a = shadow[0];
    b = shadow[1];
    c = shadow[2];
    `CHK("ss enable", a[7], ss_en)
    `CHK("multiplier", a[6:4], mult)
    `CHK("scale", a[2:0], scale)
    `CHK("custom", a[2:0] == 3'h0, custom)
    `CHK("zero loadline", b[3], zll)
    `CHK("gain", b[2:0], gain)
    `CHK("negative", c[5] & (c[4:0] != 5'h00), neg)
    `CHK("magnitude", c[4:0], mag)
  endtask : check_fields

  task automatic reset_dut;
    rst_b = 1'b0;
    tick(12);
    rst_b = 1'b1;
    shadow = '{8'h00, 8'hd0, 8'hc0};
    tick(4);
  endtask : reset_dut

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial
  begin
    scl = 1'b1;
    sda_m = 1'b1;
    reset_dut();
    check_fields();
    for (int o = 8'h23; o < 8'h28; o++) check_reg(8'(o));
    $display("test defaults done");
    // every code of the three-bit fields, both zero thresholds, burst writes
    for (int c = 0; c < 8; c++)
    begin
      cc = 3'(c);
      wr(DEV_ADDR_DEFAULT, 8'h24, 3, {cc[0], cc, 1'b0, cc, 4'hd, ~cc[0], cc, zc[c]});
      check_fields();
      check_reg(8'h24 + 8'(c % 3));
    end
    check_burst();
    $display("test field codes done");
    // random single writes, an unmapped offset and a foreign address among them
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      ofs = 8'h24 + {6'h00, seed[1:0]};
      wr((i % 5 == 4) ? DEV_ADDR_DEFAULT ^ 7'h01 : DEV_ADDR_DEFAULT, ofs, 1,
         {legal(ofs, seed[15:8]), 16'h0000});
      check_reg(ofs);
      check_fields();
    end
    $display("test random writes done");
    // burst running past the map end, then reset in mid-run
    wr(DEV_ADDR_DEFAULT, 8'h25, 3, {8'hd9, 8'hc7, 8'h55});
    check_reg(8'h27);
    check_fields();
    reset_dut();
    check_fields();
    check_reg(8'h25);
    $display("test burst and reset done");
    final_report();
  end

  // hang guard
  initial
  begin
    repeat (90000) @(posedge clock);
    n_fail++;
    $display("wrong value run length expected 90000 seen more");
    final_report();
  end
endmodule : tb_rara_cfg_regs

`default_nettype wire
